// file: core/aidr_defines.vh
/*
 Constants for the analog input diagnostic record: record byte layout,
 field positions, fixed codes and microsecond tick timing.
 Assumes inclusion by bare name from the core modules.
*/
`ifndef AIDR_DEFINES_VH
`define AIDR_DEFINES_VH

// ==========================================
// Record byte indices (diagnostic record)
`define AIDR_IDX_MOD_FAULT 5'h00
`define AIDR_IDX_KIND 5'h01
`define AIDR_IDX_DIAG_BITS_PER_CHANNEL 5'h02
`define AIDR_IDX_NUMCH 5'h03
`define AIDR_IDX_GRP_FAULT 5'h04
`define AIDR_IDX_CH0_FAULT 5'h05
`define AIDR_IDX_SPARE_FIRST 5'h09
`define AIDR_IDX_SPARE_LAST 5'h0C
`define AIDR_IDX_TS0 5'h0D
`define AIDR_IDX_TS3 5'h10
// ==========================================
// Input image byte offsets
`define AIDR_IMG_CH0 2'h0
`define AIDR_IMG_CH1 2'h2
// ==========================================
// Module fault flag bit positions
`define AIDR_MF_BUF_OVF 3
`define AIDR_MF_COMM_ERR 4
`define AIDR_MF_PI_LOST 6
// ==========================================
// Per-channel fault bit positions
`define AIDR_CF_PARAM 0
`define AIDR_CF_PI_LOST 5
`define AIDR_CF_UNDER 6
`define AIDR_CF_OVER 7
// ==========================================
// Fixed codes
`define AIDR_KIND_DIG_IN 7'h70
`define AIDR_KIND_ANA_IN 7'h71
`define AIDR_KIND_DIG_OUT 7'h72
`define AIDR_KIND_ANA_OUT 7'h73
`define AIDR_KIND_ANA_IO 7'h74
`define AIDR_KIND_COUNTER 7'h76
`define AIDR_DIAG_BITS_PER_CHANNEL_VAL 8'h08
`define AIDR_NUMCH_VAL 8'h04
// ==========================================
// Timing
`define AIDR_CLK_HZ 20000000
`define AIDR_TICK_NS 1000
`define AIDR_CLK_NS (1000000000 / `AIDR_CLK_HZ)
`define AIDR_TICK_CYC (`AIDR_TICK_NS / `AIDR_CLK_NS)
`define AIDR_TICK_W 5

`endif

// file: core/aidr_diag_record.v
/*
 Read-only diagnostic record and input image of a two-channel analog
 input module. Byte-wide read ports for record and image; writes are
 not accepted at all.
 Record bytes: 00h module faults, 01h channel kind, 02h diagnostic bits
 per channel, 03h channel count, 04h group faults, 05h..08h channel 0..3
 faults, 09h..0Ch spare channel bytes, 0Dh..10h timestamp, least
 significant byte first. Other indices read 00h.
 Image bytes: 0 and 1 channel 0 word, 2 and 3 channel 1 word, low byte
 at the even offset.
 Assumes fault conditions and sample values are synchronous to ref_clk
 and that the measuring front end sets them; a read byte appears one
 clock after its strobe and holds until the next strobe.
*/
// Function
// - Module fault bits 3,4,6: buffer overflow, communication error, interrupt lost
// - Channel kind byte holds 7-bit code, bit 7 reserved
// - Diagnostic bits per channel reads constant 08h
// - Channel count reads constant 04h
// - Group fault bit n set while channel group n has error
// - Per-channel bit 0 flags configuration or parameter error
// - Per-channel bits 5,6,7: interrupt lost, underflow, overflow
// - Spare channel bytes 4 to 7 are reserved, no information
// - Timestamp field captures microsecond count at incoming diagnostic event
// - Microsecond counter clears at power-on, counts each microsecond
// - Counter is 32 bits and wraps to zero
// - Input image: channel 0 at +0, channel 1 at +2
// - Per-channel error indicator: range, parameter, or enabled wire break
// - Departing event signalled automatically when the last cause disappears
// - Module fault indicator lit from first incoming to last departing
`timescale 1ns/1ps
`include "aidr_defines.vh"

module aidr_diag_record (
    input wire ref_clk,
    input wire rst,
    input wire [6:0] kind_code,
    input wire buf_overflow,
    input wire comm_error,
    input wire pi_lost_module,
    input wire [3:0] param_error,
    input wire [3:0] pi_lost_ch,
    input wire [3:0] range_under,
    input wire [3:0] range_over,
    input wire [3:0] wire_break,
    input wire [3:0] wire_break_en,
    input wire [15:0] sample_ch0,
    input wire [15:0] sample_ch1,
    input wire sample_valid,
    input wire [4:0] rec_addr,
    input wire rec_rd,
    output reg [7:0] rec_data,
    input wire [1:0] img_addr,
    input wire img_rd,
    output reg [7:0] img_data,
    output reg [3:0] channel_error_led,
    output reg module_fault_indicator,
    output reg diag_incoming,
    output reg diag_going
);

// ==========================================
// Microsecond counter
wire [31:0] us_count;

aidr_us_ticker u_ticker (
    .ref_clk(ref_clk),
    .rst(rst),
    .us_count_reg(us_count)
);

// ==========================================
// Module fault flags
reg [7:0] mod_fault_reg;
reg [7:0] mod_fault_next;

always @* begin
    mod_fault_next = 8'h00;
    mod_fault_next[`AIDR_MF_BUF_OVF] = buf_overflow;
    mod_fault_next[`AIDR_MF_COMM_ERR] = comm_error;
    mod_fault_next[`AIDR_MF_PI_LOST] = pi_lost_module;
end

always @(posedge ref_clk) begin
    if (rst) begin
        mod_fault_reg <= 8'h00;
    end else begin
        mod_fault_reg <= mod_fault_next;
    end
end

// ==========================================
// Per-channel fault bytes, group bits and error lamps
// Channel n forms group n on its own, so group and channel share an index
wire [31:0] ch_fault_next;
wire [3:0] grp_fault_bit;
wire [3:0] ch_lamp_next;
reg [31:0] ch_fault_reg;
reg [7:0] grp_fault_reg;

genvar g;
generate
    for (g = 0; g < 4; g = g + 1) begin : g_chan
        wire wire_break_live;
        wire [7:0] byte_next;
        assign wire_break_live = wire_break[g] & wire_break_en[g];
        assign byte_next[`AIDR_CF_PARAM] = param_error[g];
        // Bits 4..1 have no cause and stay low
        assign byte_next[4:1] = 4'h0;
        assign byte_next[`AIDR_CF_PI_LOST] = pi_lost_ch[g];
        assign byte_next[`AIDR_CF_UNDER] = range_under[g];
        assign byte_next[`AIDR_CF_OVER] = range_over[g];
        assign ch_fault_next[8*g +: 8] = byte_next;
        // A broken wire is only an error where its detection is enabled
        assign grp_fault_bit[g] = (|byte_next) | wire_break_live;
        assign ch_lamp_next[g] = range_under[g] | range_over[g] | param_error[g]
            | wire_break_live;
    end
endgenerate

always @(posedge ref_clk) begin
    if (rst) begin
        ch_fault_reg <= 32'h00000000;
        grp_fault_reg <= 8'h00;
        channel_error_led <= 4'h0;
    end else begin
        ch_fault_reg <= ch_fault_next;
        grp_fault_reg <= {4'h0, grp_fault_bit};
        channel_error_led <= ch_lamp_next;
    end
end

// ==========================================
// Diagnostic window events
wire any_fault_next;
wire window_opens;
wire window_closes;
reg any_fault_d_reg;

assign any_fault_next = (|mod_fault_next) | (|grp_fault_bit);
assign window_opens = any_fault_next & ~any_fault_d_reg;
assign window_closes = ~any_fault_next & any_fault_d_reg;

// Delay register resets to the idle level, so reset makes no false event
always @(posedge ref_clk) begin
    if (rst) begin
        any_fault_d_reg <= 1'b0;
        diag_incoming <= 1'b0;
        diag_going <= 1'b0;
        module_fault_indicator <= 1'b0;
    end else begin
        any_fault_d_reg <= any_fault_next;
        diag_incoming <= window_opens;
        // Going is raised by the block alone once every cause is gone
        diag_going <= window_closes;
        module_fault_indicator <= any_fault_next;
    end
end

// ==========================================
// Diagnostic timestamp
// Only the opening of a window is stamped; later causes inside it are lost
reg [31:0] diag_timestamp_reg;

always @(posedge ref_clk) begin
    if (rst) begin
        diag_timestamp_reg <= 32'h00000000;
    end else if (window_opens) begin
        diag_timestamp_reg <= us_count;
    end
end

// ==========================================
// Channel kind code
reg [7:0] kind_reg;

always @(posedge ref_clk) begin
    if (rst) begin
        kind_reg <= 8'h00;
    end else begin
        kind_reg <= {1'b0, kind_code};
    end
end

// ==========================================
// Record byte views
wire [7:0] ch0_fault_byte;
wire [7:0] ch1_fault_byte;
wire [7:0] ch2_fault_byte;
wire [7:0] ch3_fault_byte;
wire [7:0] spare_channel_fault_4;
wire [7:0] spare_channel_fault_5;
wire [7:0] spare_channel_fault_6;
wire [7:0] spare_channel_fault_7;
wire [7:0] ts_byte0;
wire [7:0] ts_byte1;
wire [7:0] ts_byte2;
wire [7:0] ts_byte3;

assign ch0_fault_byte = ch_fault_reg[7:0];
assign ch1_fault_byte = ch_fault_reg[15:8];
assign ch2_fault_byte = ch_fault_reg[23:16];
assign ch3_fault_byte = ch_fault_reg[31:24];
// Spare channel bytes carry no error information
assign spare_channel_fault_4 = 8'h00;
assign spare_channel_fault_5 = 8'h00;
assign spare_channel_fault_6 = 8'h00;
assign spare_channel_fault_7 = 8'h00;
assign ts_byte0 = diag_timestamp_reg[7:0];
assign ts_byte1 = diag_timestamp_reg[15:8];
assign ts_byte2 = diag_timestamp_reg[23:16];
assign ts_byte3 = diag_timestamp_reg[31:24];

// ==========================================
// Input image capture
// Both words load on one strobe so a reader never sees a mixed pair
reg [15:0] analog_value_ch0_reg;
reg [15:0] analog_value_ch1_reg;

always @(posedge ref_clk) begin
    if (rst) begin
        analog_value_ch0_reg <= 16'h0000;
        analog_value_ch1_reg <= 16'h0000;
    end else if (sample_valid) begin
        analog_value_ch0_reg <= sample_ch0;
        analog_value_ch1_reg <= sample_ch1;
    end
end

// Image byte views, little-endian words
wire [7:0] img_ch0_lo;
wire [7:0] img_ch0_hi;
wire [7:0] img_ch1_lo;
wire [7:0] img_ch1_hi;

assign img_ch0_lo = analog_value_ch0_reg[7:0];
assign img_ch0_hi = analog_value_ch0_reg[15:8];
assign img_ch1_lo = analog_value_ch1_reg[7:0];
assign img_ch1_hi = analog_value_ch1_reg[15:8];

// ==========================================
// Record read port
// There is no write path at all, so bus writes cannot alter any field
reg [7:0] rec_data_next;

always @* begin
    rec_data_next = rec_data;
    if (rec_rd) begin
        case (rec_addr)
            `AIDR_IDX_MOD_FAULT: rec_data_next = mod_fault_reg;
            `AIDR_IDX_KIND: rec_data_next = kind_reg;
            `AIDR_IDX_DIAG_BITS_PER_CHANNEL: rec_data_next = `AIDR_DIAG_BITS_PER_CHANNEL_VAL;
            `AIDR_IDX_NUMCH: rec_data_next = `AIDR_NUMCH_VAL;
            `AIDR_IDX_GRP_FAULT: rec_data_next = grp_fault_reg;
            `AIDR_IDX_CH0_FAULT: rec_data_next = ch0_fault_byte;
            5'h06: rec_data_next = ch1_fault_byte;
            5'h07: rec_data_next = ch2_fault_byte;
            5'h08: rec_data_next = ch3_fault_byte;
            `AIDR_IDX_SPARE_FIRST: rec_data_next = spare_channel_fault_4;
            5'h0A: rec_data_next = spare_channel_fault_5;
            5'h0B: rec_data_next = spare_channel_fault_6;
            `AIDR_IDX_SPARE_LAST: rec_data_next = spare_channel_fault_7;
            `AIDR_IDX_TS0: rec_data_next = ts_byte0;
            5'h0E: rec_data_next = ts_byte1;
            5'h0F: rec_data_next = ts_byte2;
            `AIDR_IDX_TS3: rec_data_next = ts_byte3;
            default: rec_data_next = 8'h00;
        endcase
    end
end

// Read byte holds until the next strobe
always @(posedge ref_clk) begin
    if (rst) begin
        rec_data <= 8'h00;
    end else begin
        rec_data <= rec_data_next;
    end
end

// ==========================================
// Image read port
reg [7:0] img_data_next;

always @* begin
    img_data_next = img_data;
    if (img_rd) begin
        case (img_addr)
            `AIDR_IMG_CH0: img_data_next = img_ch0_lo;
            2'h1: img_data_next = img_ch0_hi;
            `AIDR_IMG_CH1: img_data_next = img_ch1_lo;
            2'h3: img_data_next = img_ch1_hi;
            default: img_data_next = 8'h00;
        endcase
    end
end

always @(posedge ref_clk) begin
    if (rst) begin
        img_data <= 8'h00;
    end else begin
        img_data <= img_data_next;
    end
end

endmodule // aidr_diag_record

// file: core/aidr_us_ticker.v
/*
 Free-running 32-bit microsecond counter with divided tick.
 Assumes one clock at the rate in the defines and a synchronous reset.
*/
`timescale 1ns/1ps
`include "aidr_defines.vh"

module aidr_us_ticker (
    input wire ref_clk,
    input wire rst,
    output reg [31:0] us_count_reg
);

// ==========================================
// Divider
localparam integer TICK_LAST = `AIDR_TICK_CYC - 1;
// Last divider count, cut to the divider width on purpose
wire [31:0] tick_last_full = TICK_LAST;
reg [`AIDR_TICK_W-1:0] div_reg;
wire tick = (div_reg == tick_last_full[`AIDR_TICK_W-1:0]);

always @(posedge ref_clk) begin
    if (rst) begin
        div_reg <= {`AIDR_TICK_W{1'b0}};
        us_count_reg <= 32'h0;
    end else begin
        if (tick) begin
            div_reg <= {`AIDR_TICK_W{1'b0}};
            // Natural wrap at all ones
            us_count_reg <= us_count_reg + 32'h1;
        end else begin
            div_reg <= div_reg + {{(`AIDR_TICK_W-1){1'b0}}, 1'b1};
        end
    end
end

endmodule // aidr_us_ticker

// file: testbench/aidr_coupler_model.sv
/* Backplane coupler model: byte reads of record and image.
 Assumes the bench calls rd from one process. */
`timescale 1ns/1ps
module aidr_coupler_model (
    input wire ref_clk,
    output reg [4:0] rec_addr,
    output reg rec_rd,
    output reg [1:0] img_addr,
    output reg img_rd,
    input wire [7:0] rec_data,
    input wire [7:0] img_data
);
    initial begin
        {rec_addr, rec_rd, img_addr, img_rd} = 9'h000;
    end
    task rd(input bit img, input [4:0] a, output [7:0] d);
        begin
            @(posedge ref_clk);
            rec_addr <= a;
            img_addr <= a[1:0];
            rec_rd <= !img;
            img_rd <= img;
            @(posedge ref_clk);
            {rec_rd, img_rd} <= 2'b00;
            // Released address shows its inverse, not the last value
            {rec_addr, img_addr} <= {~a, ~a[1:0]};
            #1 d = img ? img_data : rec_data;
        end
    endtask
endmodule // aidr_coupler_model

// file: testbench/aidr_diag_record_test.sv
/* Self-checking bench for aidr_diag_record.
 Assumes the coupler model and the bound monitor. */
`timescale 1ns/1ps
module aidr_diag_record_test;
    reg ref_clk = 1'b0;
    reg rst = 1'b1;
    reg [6:0] kind_code = 7'h71;
    reg buf_overflow = 1'b0, comm_error = 1'b0, pi_lost_module = 1'b0, sample_valid = 1'b0;
    reg [3:0] param_error = 4'h0, pi_lost_ch = 4'h0, range_under = 4'h0, range_over = 4'h0;
    reg [3:0] wire_break = 4'h0, wire_break_en = 4'h0;
    reg [15:0] sample_ch0 = 16'h0000, sample_ch1 = 16'h0000;
    wire [4:0] rec_addr;
    wire [1:0] img_addr;
    wire rec_rd, img_rd, module_fault_indicator, diag_incoming, diag_going;
    wire [7:0] rec_data, img_data;
    wire [3:0] channel_error_led;
    integer failures = 0, samples_checked = 0, i, k;
    reg [31:0] seed = 32'h00000034, t0, t1;
    reg [7:0] d;
    time tr;
    always #25 ref_clk = ~ref_clk;
    aidr_diag_record uut (.*);
    aidr_coupler_model cpl (.*);
    // ==========
    // Helpers
    function [31:0] xs(input [31:0] s);
        xs = s ^ (s << 13);
        xs = xs ^ (xs >> 17);
        xs = xs ^ (xs << 5);
    endfunction
    function [3:0] led_exp();
        led_exp = param_error | range_under | range_over | (wire_break & wire_break_en);
    endfunction
    task check(input [31:0] seen, input [31:0] exp, input [8*8:1] w);
        samples_checked = samples_checked + 1;
        if (seen !== exp) begin
            failures = failures + 1;
            $display("unexpected at %0t: %0s got %0h", $time, w, seen);
        end
    endtask
    task rc(input bit img, input [4:0] a, input [7:0] e);
        cpl.rd(img, a, d);
        check(d, e, "byte");
    endtask
    task rd_ts(output [31:0] t);
        for (k = 0; k < 4; k = k + 1) begin
            cpl.rd(0, 5'h0D + k[4:0], d);
            t[8*k +: 8] = d;
        end
    endtask
    task report_and_stop;
        $display("checked %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // Whole run is near 1100 cycles; allow about nine times that
    initial begin
        #500000;
        failures = failures + 1;
        report_and_stop;
    end
    initial begin
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (5) @(posedge ref_clk);
        comm_error <= 1'b1;
        repeat (4) @(posedge ref_clk);
        rd_ts(t0);
        // Event came well under one microsecond after reset
        check(t0, 32'h00000000, "ts0");
        for (k = 0; k < 3; k = k + 1) begin
            @(posedge ref_clk);
            {pi_lost_module, comm_error, buf_overflow} <= 3'b001 << k;
            repeat (3) @(posedge ref_clk);
            rc(0, 5'h00, k == 2 ? 8'h40 : 8'h08 << k);
        end
        @(posedge ref_clk);
        pi_lost_module <= 1'b0;
        repeat (6) @(posedge ref_clk);
        buf_overflow <= 1'b1;
        tr = $time;
        repeat (4) @(posedge ref_clk);
        rd_ts(t0);
        @(posedge ref_clk);
        buf_overflow <= 1'b0;
        // 400 cycles between the two raises is 20 us
        while ($time < tr + 20000) @(posedge ref_clk);
        buf_overflow <= 1'b1;
        repeat (4) @(posedge ref_clk);
        rd_ts(t1);
        check(t1 - t0, 32'd20, "ts step");
        @(posedge ref_clk);
        buf_overflow <= 1'b0;
        for (k = 0; k < 6; k = k + 1) begin
            @(posedge ref_clk);
            kind_code <= 7'h70 + k[6:0] + (k == 5);
            repeat (3) @(posedge ref_clk);
            rc(0, 5'h01, {1'b0, kind_code});
        end
        $display("fixed fields done");
        for (i = 0; i < 20; i = i + 1) begin
            @(posedge ref_clk);
            seed = xs(seed);
            {param_error, pi_lost_ch, range_under, range_over} <= seed[15:0];
            {wire_break, wire_break_en} <= seed[23:16];
            {sample_ch0, sample_ch1, sample_valid} <= {seed, 1'b1};
            @(posedge ref_clk);
            sample_valid <= 1'b0;
            repeat (3) @(posedge ref_clk);
            rc(0, 5'h04, {4'h0, led_exp() | pi_lost_ch});
            for (k = 0; k < 4; k = k + 1) begin
                rc(0, 5'h05 + k[4:0], {range_over[k], range_under[k], pi_lost_ch[k], 4'h0,
                    param_error[k]});
                rc(1, k[4:0], seed[8*(3 - (k ^ 1)) +: 8]);
            end
            rc(0, 5'h09 + seed[1:0], 8'h00);
            rc(0, 5'h11 + seed[4:2], 8'h00);
            rc(0, 5'h02 + seed[5], seed[5] ? 8'h04 : 8'h08);
            check(channel_error_led, led_exp(), "led");
        end
        $display("random faults done");
        @(posedge ref_clk);
        {param_error, pi_lost_ch, range_under, range_over, wire_break} <= 20'h00000;
        repeat (6) @(posedge ref_clk);
        check(module_fault_indicator, 1'b0, "mf");
        $display("indicator test done");
        report_and_stop;
    end
endmodule // aidr_diag_record_test

// file: testbench/aidr_monitor.sv
/* Assertions on the record ports.
 Bound into every aidr_diag_record. */
`timescale 1ns/1ps
module aidr_monitor (
    input wire ref_clk,
    input wire rst,
    input wire [6:0] kind_code,
    input wire buf_overflow,
    input wire comm_error,
    input wire pi_lost_module,
    input wire [3:0] param_error,
    input wire [3:0] pi_lost_ch,
    input wire [3:0] range_under,
    input wire [3:0] range_over,
    input wire [3:0] wire_break,
    input wire [3:0] wire_break_en,
    input wire [4:0] rec_addr,
    input wire rec_rd,
    input wire [7:0] rec_data,
    input wire [3:0] channel_error_led,
    input wire module_fault_indicator,
    input wire diag_incoming,
    input wire diag_going
);
    // ==========
    // Causes
    wire [3:0] bad = param_error | range_under | range_over | (wire_break & wire_break_en);
    wire any_f = buf_overflow | comm_error | pi_lost_module | (|(bad | pi_lost_ch));
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    a_diag_bits_per_channel_const: assert property (rec_rd && rec_addr == 5'h02 |=> rec_data == 8'h08)
        else $error("bits per channel wrong");
    a_numch_const: assert property (rec_rd && rec_addr == 5'h03 |=> rec_data == 8'h04)
        else $error("channel count wrong");
    a_kind_byte: assert property (
        rec_rd && rec_addr == 5'h01 |=> rec_data == {1'b0, $past(kind_code, 2)})
        else $error("kind byte wrong");
    a_spare_zero: assert property (
        rec_rd && rec_addr inside {[5'h09:5'h0C]} |=> rec_data == 8'h00)
        else $error("spare byte not zero");
    a_group_resvd: assert property (
        rec_rd && rec_addr == 5'h04 |=> rec_data[7:4] == 4'h0)
        else $error("group reserved bits set");
    a_led_follow: assert property ($stable(bad)[*3] |-> channel_error_led == bad)
        else $error("error led wrong");
    a_incoming_event: assert property ($rose(any_f) |-> ##[1:3] diag_incoming)
        else $error("no incoming event");
    a_going_event: assert property ($fell(any_f) |-> ##[1:3] diag_going)
        else $error("no going event");
    a_indicator_lit: assert property (diag_incoming |-> module_fault_indicator)
        else $error("indicator dark on event");
    a_indicator_off: assert property ((!any_f)[*5] |-> !module_fault_indicator)
        else $error("indicator lit when quiet");
    c_in: cover property (diag_incoming);
    c_go: cover property (diag_going);
    c_ts: cover property (rec_rd && rec_addr == 5'h0D);
endmodule // aidr_monitor
bind aidr_diag_record aidr_monitor mon (.*);
